// File: dv/cim_id_filter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cim_id_filter_tb_top;
  import cim_pkg::*;
  logic        ref_clk_i = 0, rst_b_i = 0, ce_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
  logic        ext_r = 0, rx_en = 0, rx_valid, rx_rtr, rx_ide, accept, tx_rtr, tx_rb1, tx_rb0;
  logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata, rdata, b, tag[4], msk[4];
  logic [28:0] rx_id, tx_id, fid, flip;
  logic        frtr, fide, exp_acc;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'hdd3a36cc;

  cim_id_filter i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata), .extended_format_select_i(ext_r),
    .rx_enable_i(rx_en), .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_rtr_i(rx_rtr),
    .rx_ide_i(rx_ide), .accept_o(accept), .tx_id_o(tx_id), .tx_rtr_o(tx_rtr),
    .tx_rb1_o(tx_rb1), .tx_rb0_o(tx_rb0));
  cim_pe_model i_pe (.ref_clk_i(ref_clk_i), .rx_valid_o(rx_valid), .rx_id_o(rx_id),
    .rx_rtr_o(rx_rtr), .rx_ide_o(rx_ide));

  initial forever #25 ref_clk_i = ~ref_clk_i;

  // ****************************
  // Reference model
  // ****************************
  function automatic logic [7:0] addr_of(int k);
    return (k < 4) ? 8'(8'hbc + k) : (k < 8) ? 8'(8'hc0 + k) : 8'hc0;
  endfunction : addr_of
  // Readable bits of each byte in the current layout
  function automatic logic [7:0] rd_mask(int k);
    if (k > 7) return 8'h00;
    if (ext_r) return (k == 7) ? 8'hfd : 8'hff;
    case (k % 4)
      0: return 8'hff;
      1: return 8'he0;
      2: return 8'h00;
      default: return 8'h05;
    endcase
  endfunction : rd_mask
  function automatic logic [28:0] id_of(input logic [7:0] v [4]);
    return ext_r ? {v[0], v[1], v[2], v[3][7:3]} : {18'h0, v[0], v[1][7:5]};
  endfunction : id_of

  // ****************************
  // Bus tasks and compare
  // ****************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(int k, logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b1;
    sfr_addr_i = addr_of(k);
    sfr_wdata_i = d;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rd(int k, output logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b1;
    sfr_addr_i = addr_of(k);
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_b_i = 1'b1;
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        // Mid-run reset clears tag one and the transmit id
        @(negedge ref_clk_i) rst_b_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        rd(0, rdata);
        chk("reset_tag_one", 8'h00, rdata);
        chk("reset_tx_id", 32'h0, tx_id);
      end
      ext_r = 1'($random(seed));
      rx_en = (i % 5) != 4;
      for (int k = 0; k < 8; k++) begin
        b = 8'($random(seed)) & rd_mask(k);
        if (k < 4) tag[k] = b;
        else msk[k-4] = b;
        wr(k, b);
      end
      for (int k = 0; k < 9; k++) begin
        rd(k, rdata);
        chk("sfr_rdata", (k < 8) ? ((k < 4) ? tag[k] : msk[k-4]) : 8'h00, rdata);
      end
      chk("tx_id", id_of(tag), tx_id);
      chk("tx_bits", {tag[3][2], ext_r & tag[3][1], tag[3][0]}, {tx_rtr, tx_rb1, tx_rb0});
      // Clock enable low must drop the write
      @(negedge ref_clk_i) ce_i = 1'b0;
      wr(0, ~tag[0]);
      ce_i = 1'b1;
      rd(0, rdata);
      chk("ce_frozen_tag", tag[0], rdata);
      for (int j = 0; j < 2; j++) begin
        flip = 29'($random(seed));
        if (j == 0) flip = flip & ~id_of(msk);
        fid = (id_of(tag) ^ flip) & (ext_r ? 29'h1fffffff : 29'h7ff);
        frtr = 1'($random(seed));
        fide = 1'($random(seed));
        exp_acc = rx_en && (((fid ^ id_of(tag)) & id_of(msk)) == 0)
                  && !(msk[3][2] && frtr != tag[3][2]) && !(msk[3][0] && fide != ext_r);
        i_pe.send(fid, frtr, fide);
        chk("accept", exp_acc, accept);
      end
      $display("test %0d done", i);
    end
    results();
  end
endmodule : cim_id_filter_tb_top
`default_nettype wire

// File: dv/cim_pe_model.sv
`timescale 1ns/1ns
`default_nettype none
module cim_pe_model (
  // Clock
  input  wire logic                         ref_clk_i,
  // Received frame toward the filter
  output logic                              rx_valid_o,
  output logic      [cim_pkg::EXT_ID_W-1:0] rx_id_o,
  output logic                              rx_rtr_o,
  output logic                              rx_ide_o
);
  import cim_pkg::*;
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o    = '0;
    rx_rtr_o   = 1'b0;
    rx_ide_o   = 1'b0;
  end
  // One-cycle frame; fields are driven inverted after it so stale values match only when every set id, rtr and extension mask bit was a mismatch in the frame
  task automatic send(input logic [EXT_ID_W-1:0] id, input logic rtr, input logic extended_format_select);
    @(negedge ref_clk_i);
    rx_valid_o = 1'b1;
    rx_id_o    = id;
    rx_rtr_o   = rtr;
    rx_ide_o   = extended_format_select;
    @(negedge ref_clk_i);
    rx_valid_o = 1'b0;
    rx_id_o    = ~id;
    rx_rtr_o   = ~rtr;
    rx_ide_o   = ~extended_format_select;
  endtask : send
endmodule : cim_pe_model
`default_nettype wire

// File: rtl/cim_accept_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module cim_accept_cmp
  import cim_pkg::*;
(
  // Stored filter
  input  wire logic [cim_pkg::EXT_ID_W-1:0] tag_id_i,
  input  wire logic [cim_pkg::EXT_ID_W-1:0] msk_id_i,
  input  wire logic                         tag_rtr_i,
  input  wire logic                         msk_rtr_i,
  input  wire logic                         msk_ide_i,
  input  wire logic                         ext_fmt_i,
  // Received frame fields
  input  wire logic [cim_pkg::EXT_ID_W-1:0] rx_id_i,
  input  wire logic                         rx_rtr_i,
  input  wire logic                         rx_ide_i,
  // Result
  output logic                              match_o
);
  logic id_ok;
  logic rtr_ok;
  logic ide_ok;

  assign id_ok  = ~|((tag_id_i ^ rx_id_i) & msk_id_i);
  assign rtr_ok = ~((tag_rtr_i ^ rx_rtr_i) & msk_rtr_i);
  assign ide_ok = ~((ext_fmt_i ^ rx_ide_i) & msk_ide_i);
  assign match_o = id_ok & rtr_ok & ide_ok;

endmodule : cim_accept_cmp
`default_nettype wire

// File: rtl/cim_id_filter.sv
// What this block does
// - Standard layout: id 10..3 in tag one, id 2..0 in tag two bits 7..5.
// - Extended layout: 29-bit id spread over four tag registers, top first.
// - Extended tag four: rtr tag bit 2, reserved-1 bit 1, reserved-0 bit 0.
// - Standard tag four: rtr bit 2, reserved-0 bit 0; tag three reserved.
// - Mask bit 0 forces match; mask bit 1 requires equality with tag.
// - Standard mask: bits 10..3 in mask one, 2..0 in mask two 7..5.
// - Mask four: rtr mask bit 2, extension mask bit 0.
// - Mask used only for receive filtering; transmit uses raw tags.
// - Extension setting 0 selects standard layout, 1 extended.
`timescale 1ns/1ns
`default_nettype none
module cim_id_filter
  import cim_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         ce_i,
  // SFR bus
  input  wire logic [cim_pkg::SFR_AW-1:0]   sfr_addr_i,
  input  wire logic [cim_pkg::SFR_DW-1:0]   sfr_wdata_i,
  input  wire logic                         sfr_wr_i,
  input  wire logic                         sfr_rd_i,
  output logic      [cim_pkg::SFR_DW-1:0]   sfr_rdata_o,
  // Object configuration
  input  wire logic                         extended_format_select_i,
  input  wire logic                         rx_enable_i,
  // Received frame from protocol engine
  input  wire logic                         rx_valid_i,
  input  wire logic [cim_pkg::EXT_ID_W-1:0] rx_id_i,
  input  wire logic                         rx_rtr_i,
  input  wire logic                         rx_ide_i,
  // Filter result and transmit fields
  output logic                              accept_o,
  output logic      [cim_pkg::EXT_ID_W-1:0] tx_id_o,
  output logic                              tx_rtr_o,
  output logic                              tx_rb1_o,
  output logic                              tx_rb0_o
);
  import cim_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  // id assembly per layout
  function automatic logic [EXT_ID_W-1:0] join_id(input logic [3:0][7:0] b,
                                                  input logic            ext);
    logic [EXT_ID_W-1:0] v;
    v = '0;
    if (ext) begin
      v = {b[0], b[1], b[2], b[3][7:3]};
    end else begin
      v = {{(EXT_ID_W-STD_ID_W){1'b0}}, b[0], b[1][7:5]};
    end
    return v;
  endfunction : join_id

  // Reserved positions read as zero in the chosen layout
  function automatic logic [7:0] rd_keep(input logic [SFR_AW-1:0] a,
                                         input logic              ext);
    logic [7:0] k;
    k = RD_NONE;
    case (a)
      TAG_REG_ONE_ADDR,
      MASK_REG_ONE_ADDR:   k = RD_ALL;
      TAG_REG_TWO_ADDR,
      MASK_REG_TWO_ADDR:   k = ext ? RD_ALL : STD_TWO_RD;
      TAG_REG_THREE_ADDR,
      MASK_REG_THREE_ADDR: k = ext ? RD_ALL : RD_NONE;
      TAG_REG_FOUR_ADDR:   k = ext ? RD_ALL : STD_TAG_FOUR_RD;
      MASK_REG_FOUR_ADDR:  k = ext ? EXT_MSK_FOUR_RD : STD_MSK_FOUR_RD;
      default:             k = RD_NONE;
    endcase
    return k;
  endfunction : rd_keep

  // ****************************************
  // State and comparison
  // ****************************************
  cim_state_t          st_r;
  cim_state_t          st_nxt;
  logic [EXT_ID_W-1:0] tag_id;
  logic [EXT_ID_W-1:0] msk_id;
  logic                match;
  logic                tag_hit;
  logic                msk_hit;
  logic [1:0]          sel;
  logic [7:0]          rd_raw;

  assign tag_id  = join_id(st_r.tag, extended_format_select_i);
  assign msk_id  = join_id(st_r.msk, extended_format_select_i);
  assign sel     = sfr_addr_i[1:0];
  assign tag_hit = (sfr_addr_i[SFR_AW-1:2] == TAG_REG_ONE_ADDR[SFR_AW-1:2]);
  assign msk_hit = (sfr_addr_i[SFR_AW-1:2] == MASK_REG_ONE_ADDR[SFR_AW-1:2]);
  assign rd_raw  = tag_hit ? st_r.tag[sel] : (msk_hit ? st_r.msk[sel] : RD_NONE);

  cim_accept_cmp u_cmp (
    .tag_id_i  (tag_id),
    .msk_id_i  (msk_id),
    .tag_rtr_i (st_r.tag[3][RTR_BIT]),
    .msk_rtr_i (st_r.msk[3][RTR_BIT]),
    .msk_ide_i (st_r.msk[3][IDE_MSK_BIT]),
    .ext_fmt_i (extended_format_select_i),
    .rx_id_i   (rx_id_i),
    .rx_rtr_i  (rx_rtr_i),
    .rx_ide_i  (rx_ide_i),
    .match_o   (match)
  );

  always_comb begin
    st_nxt = st_r;
    // Raw bytes kept so a layout switch keeps software's values
    if (sfr_wr_i && tag_hit) begin
      st_nxt.tag[sel] = sfr_wdata_i;
    end
    if (sfr_wr_i && msk_hit) begin
      st_nxt.msk[sel] = sfr_wdata_i;
    end
    if (sfr_rd_i) begin
      st_nxt.rdata = rd_raw & rd_keep(sfr_addr_i, extended_format_select_i);
    end
    // accept pulse for enabled receive object
    st_nxt.accept = rx_valid_i & rx_enable_i & match;
    st_nxt.tx_id  = tag_id;
    st_nxt.tx_rtr = st_r.tag[3][RTR_BIT];
    st_nxt.tx_rb1 = extended_format_select_i & st_r.tag[3][RB1_BIT];
    st_nxt.tx_rb0 = st_r.tag[3][RB0_BIT];
  end

  // Contents undefined to software; zero gives a known start anyway
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o = st_r.rdata;
  assign accept_o    = st_r.accept;
  assign tx_id_o     = st_r.tx_id;
  assign tx_rtr_o    = st_r.tx_rtr;
  assign tx_rb1_o    = st_r.tx_rb1;
  assign tx_rb0_o    = st_r.tx_rb0;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic all_open;
  assign all_open = (msk_id == '0) && !st_r.msk[3][RTR_BIT] && !st_r.msk[3][IDE_MSK_BIT];

  open_accept_a: assert property (
    (ce_i && rx_valid_i && rx_enable_i && all_open) |=> accept_o)
    else $error("open mask did not accept");
  id_reject_a: assert property (
    (ce_i && rx_valid_i && (((tag_id ^ rx_id_i) & msk_id) != '0)) |=> !accept_o)
    else $error("masked id mismatch accepted");
  disabled_obj_a: assert property (
    (ce_i && !rx_enable_i) |=> !accept_o)
    else $error("disabled object accepted");
  ide_reject_a: assert property (
    (ce_i && rx_valid_i && st_r.msk[3][IDE_MSK_BIT]
     && (rx_ide_i != extended_format_select_i)) |=> !accept_o)
    else $error("extension mismatch accepted");
  std_layout_a: assert property (
    (ce_i && !extended_format_select_i)
    |=> tx_id_o == {18'h0, $past(st_r.tag[0]), $past(st_r.tag[1][7:5])})
    else $error("standard id layout wrong");
  ext_layout_a: assert property (
    (ce_i && extended_format_select_i)
    |=> tx_id_o[4:0] == $past(st_r.tag[3][7:3]) && tx_id_o[28:21] == $past(st_r.tag[0]))
    else $error("extended id layout wrong");
  ext_rb1_a: assert property (
    (ce_i && extended_format_select_i) |=> tx_rb1_o == $past(st_r.tag[3][1]))
    else $error("reserved-1 tag not sent");
  std_tag3_a: assert property (
    (ce_i && sfr_rd_i && sfr_addr_i == TAG_REG_THREE_ADDR && !extended_format_select_i)
    |=> sfr_rdata_o == 8'h00)
    else $error("standard tag three not reserved");
  std_msk2_a: assert property (
    (ce_i && sfr_rd_i && sfr_addr_i == MASK_REG_TWO_ADDR && !extended_format_select_i)
    |=> sfr_rdata_o[4:0] == 5'h00 && sfr_rdata_o[7:5] == $past(st_r.msk[1][7:5]))
    else $error("standard mask two layout wrong");
  tx_unmasked_a: assert property (
    (ce_i && sfr_wr_i && msk_hit && $stable(st_r.tag) && $stable(extended_format_select_i))
    ##1 (ce_i && $stable(extended_format_select_i)) |=> $stable(tx_id_o))
    else $error("mask write changed transmit id");

  rtr_reject_a: assert property (
    (ce_i && rx_valid_i && st_r.msk[3][RTR_BIT] && (rx_rtr_i != st_r.tag[3][RTR_BIT]))
    |=> !accept_o)
    else $error("remote request mismatch accepted");
  tx_rtr_a: assert property (
    ce_i |=> tx_rtr_o == $past(st_r.tag[3][RTR_BIT]))
    else $error("transmit remote request not the tag");
  tx_rb0_a: assert property (
    ce_i |=> tx_rb0_o == $past(st_r.tag[3][RB0_BIT]))
    else $error("reserved-0 tag not sent");
  std_rb1_a: assert property (
    (ce_i && !extended_format_select_i) |=> !tx_rb1_o)
    else $error("reserved-1 sent in standard layout");
  ext_msk4_a: assert property (
    (ce_i && sfr_rd_i && sfr_addr_i == MASK_REG_FOUR_ADDR && extended_format_select_i)
    |=> sfr_rdata_o[1] == 1'b0 && sfr_rdata_o[2] == $past(st_r.msk[3][RTR_BIT]))
    else $error("extended mask four layout wrong");
  ext_mid_a: assert property (
    (ce_i && extended_format_select_i)
    |=> tx_id_o[20:5] == {$past(st_r.tag[1]), $past(st_r.tag[2])})
    else $error("extended middle id bytes wrong");
  std_tag4_a: assert property (
    (ce_i && sfr_rd_i && sfr_addr_i == TAG_REG_FOUR_ADDR && !extended_format_select_i)
    |=> sfr_rdata_o[7:3] == 5'h00 && sfr_rdata_o[1] == 1'b0)
    else $error("standard tag four reserved bits read back");

  accept_seen_c: cover property (ce_i && rx_valid_i && rx_enable_i ##1 accept_o);
  ext_write_c:   cover property (ce_i && sfr_wr_i && tag_hit && extended_format_select_i);
  std_read_c:    cover property (ce_i && sfr_rd_i && msk_hit && !extended_format_select_i);
  reject_seen_c: cover property (ce_i && rx_valid_i && rx_enable_i && !match ##1 !accept_o);
  ext_accept_c:  cover property (ce_i && rx_valid_i && extended_format_select_i ##1 accept_o);

endmodule : cim_id_filter
`default_nettype wire

// File: rtl/cim_pkg.sv
package cim_pkg;

  // ****************************************
  // Register addresses on the SFR bus
  // ****************************************
  localparam logic [7:0] TAG_REG_ONE_ADDR    = 8'hbc;
  localparam logic [7:0] TAG_REG_TWO_ADDR    = 8'hbd;
  localparam logic [7:0] TAG_REG_THREE_ADDR  = 8'hbe;
  localparam logic [7:0] TAG_REG_FOUR_ADDR   = 8'hbf;
  localparam logic [7:0] MASK_REG_ONE_ADDR   = 8'hc4;
  localparam logic [7:0] MASK_REG_TWO_ADDR   = 8'hc5;
  localparam logic [7:0] MASK_REG_THREE_ADDR = 8'hc6;
  localparam logic [7:0] MASK_REG_FOUR_ADDR  = 8'hc7;

  // ****************************************
  // Widths, field positions, read masks
  // ****************************************
  localparam int         SFR_AW         = 8;
  localparam int         SFR_DW         = 8;
  localparam int         EXT_ID_W       = 29;
  localparam int         STD_ID_W       = 11;
  localparam int         RTR_BIT        = 2;
  localparam int         RB1_BIT        = 1;
  localparam int         RB0_BIT        = 0;
  localparam int         IDE_MSK_BIT    = 0;
  localparam logic [7:0] RD_ALL         = 8'hff;
  localparam logic [7:0] RD_NONE        = 8'h00;
  localparam logic [7:0] STD_TWO_RD     = 8'he0;
  localparam logic [7:0] STD_TAG_FOUR_RD = 8'h05;
  localparam logic [7:0] STD_MSK_FOUR_RD = 8'h05;
  localparam logic [7:0] EXT_MSK_FOUR_RD = 8'hfd;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ****************************************
  // Block state
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0]        tag;
    logic [3:0][7:0]        msk;
    logic [7:0]             rdata;
    logic                   accept;
    logic [EXT_ID_W-1:0]    tx_id;
    logic                   tx_rtr;
    logic                   tx_rb1;
    logic                   tx_rb0;
  } cim_state_t;

endpackage : cim_pkg
